/* File: include/spfc_pkg.sv */
// Package with constants and types of the self-program flash controller.
package spfc_pkg;

  // ****************************************************************
  // Register map and control bit layout
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_ARM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_FUSE = 3;
  localparam int BIT_CLEAR = 4;
  localparam int BIT_SIG = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_EE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Legal patterns of the lower six control bits.
  localparam logic [5:0] PAT_LOAD = 6'h01;
  localparam logic [5:0] PAT_ERASE = 6'h03;
  localparam logic [5:0] PAT_WRITE = 6'h05;
  localparam logic [5:0] PAT_FUSE = 6'h09;
  localparam logic [5:0] PAT_CLEAR = 6'h11;
  localparam logic [5:0] PAT_SIG = 6'h21;

  // ****************************************************************
  // Windows, page geometry and timing
  // ****************************************************************
  localparam logic [2:0] SPM_WINDOW = 3'h4;
  localparam logic [2:0] LPM_WINDOW = 3'h3;
  localparam int PAGE_WORDS = 64;
  localparam int WORD_W = 6;
  localparam int PAGE_W = 9;
  localparam int PROG_W = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_MIN_NS = 3700000;
  localparam int PROG_TIME_MAX_NS = 4500000;
  localparam int PROG_CYCLES_MIN = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_MAX = PROG_TIME_MAX_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Pointer values of fuse, lock and signature reads
  // ****************************************************************
  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] Z_SIG0 = 16'h0000;
  localparam logic [15:0] Z_OSC_CAL = 16'h0001;
  localparam logic [15:0] Z_SIG1 = 16'h0002;
  localparam logic [15:0] Z_TS_OFFSET = 16'h0003;
  localparam logic [15:0] Z_SIG2 = 16'h0004;
  localparam logic [15:0] Z_TS_GAIN = 16'h0005;
  localparam logic [7:0] RESERVED_BYTE = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} spfc_state_t;

  typedef struct packed {
    logic spm;
    logic lpm;
    logic [15:0] z_ptr;
    logic [15:0] data_pair;
  } spfc_cpu_req_t;

  typedef struct packed {
    logic erase;
    logic wr_en;
    logic [PAGE_W-1:0] page;
    logic [WORD_W-1:0] word;
    logic [15:0] data;
  } spfc_flash_wr_t;

endpackage : spfc_pkg

/* File: src/spfc_ctrl.sv */
// Self-program flash controller: control register, page buffer, timed erase and write, special reads.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Armed page-write command makes next store within four cycles program page from buffer.
// - Erase and write take the page number from the upper pointer bits only.
// - Page-write bit clears when the write ends or after four idle cycles.
// - Armed page-erase command makes next store within four cycles erase the page.
// - Page-erase bit clears when the erase ends or after four idle cycles.
// - CPU stays stalled for the whole erase or write.
// - Arming a store command opens a four-cycle window; later store instructions do nothing special.
// - Arm alone: next store puts the data pair into the addressed buffer word.
// - Arm of a store command clears after a store or four idle cycles, but holds during erase/write.
// - Only the six listed patterns of the lower control bits take effect.
// - EEPROM write busy blocks all self-programming and fuse/lock reads.
// - Pointer 1 with fuse/lock read armed: load within three cycles returns lock bits.
// - Fuse/lock read and arm clear after read, a store, or three idle cycles.
// - Pointer 0 with fuse/lock read armed returns the low fuse byte.
// - Pointer 3 returns high fuse byte, pointer 2 extended fuse byte.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
// - Signature read armed: load within three cycles returns the addressed row byte.
// - Signature row: ids at 0,2,4; calibration 1; sensor offset 3, gain 5.
// - Signature read and arm clear after the read or three idle cycles.
// - Erase and write last the calibrated programming time, 3.7 ms to 4.5 ms.
// - Clear-buffer command empties the temporary page buffer.
// - Buffer clears after page write and reset; each word loads once per clear.
module spfc_ctrl
  import spfc_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_MIN,
  parameter logic [7:0] SIG_BYTE0 = 8'h11,   // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE1 = 8'h22,   // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE2 = 8'h33,   // Arbitrary identity value.
  parameter logic [7:0] OSC_CAL_BYTE = 8'h80,
  parameter logic [7:0] TS_OFFSET_BYTE = 8'h00,
  parameter logic [7:0] TS_GAIN_BYTE = 8'h80
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // CPU core
  input wire spfc_cpu_req_t cpu_req,
  output logic cpu_stall,
  output logic lpm_valid,
  output logic [7:0] lpm_data,
  // EEPROM controller
  input wire logic eeprom_write_busy,
  // Fuse and lock storage, one bit high per programmed cell
  input wire logic [7:0] fuse_prog_low,
  input wire logic [7:0] fuse_prog_high,
  input wire logic [7:0] fuse_prog_ext,
  input wire logic [7:0] lock_prog,
  // Flash array
  output logic [15:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_byte,
  output spfc_flash_wr_t flash_wr
);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [5:0] ctl_q;

  // Handshake decode; a write commits once address and data are both held.
  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire commit = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = commit ? 1'b0 : (aw_full_q | aw_take);
  wire w_full_d = commit ? 1'b0 : (w_full_q | w_take);
  wire ar_take = arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~rready);
  wire wr_ctrl = aw_addr_q[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2];
  wire wr_stat = aw_addr_q[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2];
  wire rd_ctrl = araddr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2];
  wire rd_stat = araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2];
  wire [31:0] rd_word = rd_ctrl ? {24'h000000, 2'h0, ctl_q} :
                        rd_stat ? {30'h0, eeprom_write_busy, cpu_stall} : 32'h00000000;

  // Channel state; ready flags are registered inverses of the next holding state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      if (aw_take)
        aw_addr_q <= awaddr;
      if (w_take)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (commit)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl | wr_stat) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_word;
        rresp_q <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Control register, arming window and operation sequencer
  // ****************************************************************
  spfc_state_t state_q, state_d;
  logic [2:0] win_q;
  logic [PROG_W-1:0] prog_cnt_q;
  logic stall_q;
  logic [PAGE_W-1:0] page_q;
  logic [5:0] ctl_d;

  // Pattern check and command decode.
  wire [5:0] pat = w_data_q[5:0];
  wire pat_ok = (pat == PAT_LOAD) | (pat == PAT_ERASE) | (pat == PAT_WRITE) |
                (pat == PAT_FUSE) | (pat == PAT_CLEAR) | (pat == PAT_SIG);
  wire ctl_wr = commit & wr_ctrl & w_strb_q[0] & pat_ok & ~eeprom_write_busy &
                ~ctl_q[BIT_ARM];
  wire read_cmd = ctl_q[BIT_FUSE] | ctl_q[BIT_SIG];
  wire [2:0] limit = read_cmd ? LPM_WINDOW : SPM_WINDOW;
  wire idle = state_q == ST_IDLE;
  wire win_open = ctl_q[BIT_ARM] & idle & (win_q < limit);
  wire spm_take = cpu_req.spm & win_open & ~eeprom_write_busy;
  wire lpm_fuse = cpu_req.lpm & win_open & ctl_q[BIT_FUSE] & ~eeprom_write_busy;
  wire lpm_sig = cpu_req.lpm & win_open & ctl_q[BIT_SIG];
  wire expire = ctl_q[BIT_ARM] & idle & (win_q == limit - 3'h1) & ~spm_take;
  wire op_done = ~idle & (prog_cnt_q == PROG_W'(PROG_CYCLES - 1));
  wire start_erase = spm_take & ctl_q[BIT_ERASE];
  wire start_write = spm_take & ctl_q[BIT_WRITE];
  wire load_word = spm_take & (ctl_q == PAT_LOAD);

  // Next control value: end of operation first, then software, then the CPU.
  always_comb
  begin
    ctl_d = ctl_q;
    state_d = state_q;
    if (op_done)
    begin
      ctl_d = 6'h00;
      state_d = ST_IDLE;
    end
    else if (ctl_wr)
      ctl_d = pat;
    else if (start_erase)
      state_d = ST_ERASE;
    else if (start_write)
      state_d = ST_WRITE;
    else if (spm_take | lpm_fuse | lpm_sig | expire)
      ctl_d = 6'h00;
  end

  // Sequencer registers; arm stays set while busy, stall follows the state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= CTRL_RESET[5:0];
      state_q <= ST_IDLE;
      win_q <= 3'h0;
      prog_cnt_q <= '0;
      stall_q <= 1'b0;
      page_q <= '0;
    end
    else
    begin
      ctl_q <= ctl_d;
      state_q <= state_d;
      win_q <= ctl_wr ? 3'h0 : (win_q + {2'h0, ctl_q[BIT_ARM] & idle});
      prog_cnt_q <= idle ? '0 : (prog_cnt_q + PROG_W'(1));
      stall_q <= state_d != ST_IDLE;
      if (start_erase | start_write)
        page_q <= cpu_req.z_ptr[15:WORD_W+1];
    end
  end

  // ****************************************************************
  // Temporary page buffer
  // ****************************************************************
  wire [WORD_W-1:0] ld_idx = cpu_req.z_ptr[WORD_W:1];
  wire buf_clear = (ctl_wr & (pat == PAT_CLEAR)) | (op_done & (state_q == ST_WRITE)) |
                   eeprom_write_busy;
  wire [15:0] buf_word [PAGE_WORDS];

  // One valid flag and one data word per entry; a loaded word is not overwritten by a later load until a clear.
  for (genvar i = 0; i < PAGE_WORDS; i++)
  begin : g_buf
    logic vld_q;
    logic [15:0] data_q;
    wire hit = load_word & (ld_idx == WORD_W'(i)) & ~vld_q;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        vld_q <= 1'b0;
        data_q <= ERASED_WORD;
      end
      else if (buf_clear)
      begin
        vld_q <= 1'b0;
        data_q <= ERASED_WORD;
      end
      else if (hit)
      begin
        vld_q <= 1'b1;
        data_q <= cpu_req.data_pair;
      end
    end
    assign buf_word[i] = data_q;
  end

  // ****************************************************************
  // Flash write port
  // ****************************************************************
  wire [WORD_W-1:0] wr_idx = prog_cnt_q[WORD_W-1:0];
  wire stream = (state_q == ST_WRITE) & (prog_cnt_q < PROG_W'(PAGE_WORDS));
  spfc_flash_wr_t flash_wr_q;

  // Erase holds a level for the whole erase; write streams the buffer, pair data unused.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flash_wr_q <= '0;
    else
    begin
      flash_wr_q.erase <= (state_q == ST_ERASE) & ~op_done;
      flash_wr_q.wr_en <= stream;
      flash_wr_q.page <= page_q;
      flash_wr_q.word <= wr_idx;
      flash_wr_q.data <= buf_word[wr_idx];
    end
  end

  // ****************************************************************
  // Load-program read path
  // ****************************************************************
  wire [15:0] z = cpu_req.z_ptr;
  wire [7:0] fuse_byte = (z == Z_FUSE_LOW) ? ~fuse_prog_low :
                         (z == Z_LOCK) ? ~lock_prog :
                         (z == Z_FUSE_EXT) ? ~fuse_prog_ext :
                         (z == Z_FUSE_HIGH) ? ~fuse_prog_high : RESERVED_BYTE;
  wire [7:0] sig_byte = (z == Z_SIG0) ? SIG_BYTE0 : (z == Z_SIG1) ? SIG_BYTE1 :
                        (z == Z_SIG2) ? SIG_BYTE2 : (z == Z_OSC_CAL) ? OSC_CAL_BYTE :
                        (z == Z_TS_OFFSET) ? TS_OFFSET_BYTE :
                        (z == Z_TS_GAIN) ? TS_GAIN_BYTE : RESERVED_BYTE;
  logic rd_pend_q, rd_special_q, lpm_valid_q;
  logic [7:0] rd_byte_q, lpm_data_q;
  logic [15:0] rd_addr_q;

  // Two stages: capture address and special byte, then pick flash or special byte.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend_q <= 1'b0;
      rd_special_q <= 1'b0;
      rd_byte_q <= 8'h00;
      rd_addr_q <= 16'h0000;
      lpm_valid_q <= 1'b0;
      lpm_data_q <= 8'h00;
    end
    else
    begin
      rd_pend_q <= cpu_req.lpm;
      rd_special_q <= lpm_fuse | lpm_sig;
      rd_byte_q <= lpm_sig ? sig_byte : fuse_byte;
      if (cpu_req.lpm)
        rd_addr_q <= z;
      lpm_valid_q <= rd_pend_q;
      if (rd_pend_q)
        lpm_data_q <= rd_special_q ? rd_byte_q : flash_rd_byte;
    end
  end

  // Outputs straight from registers.
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign cpu_stall = stall_q;
  assign lpm_valid = lpm_valid_q;
  assign lpm_data = lpm_data_q;
  assign flash_rd_addr = rd_addr_q;
  assign flash_wr = flash_wr_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helper counter of the stall length.
  logic [PROG_W-1:0] stall_len_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stall_len_q <= '0;
    else
      stall_len_q <= stall_q ? (stall_len_q + PROG_W'(1)) : '0;
  end

  sequence s_lock_req;
    cpu_req.lpm && ctl_q == PAT_FUSE && idle && win_q < LPM_WINDOW && !eeprom_write_busy && z == Z_LOCK;
  endsequence
  sequence s_lock_answer;
    ##2 lpm_valid && lpm_data == ~$past(lock_prog, 2);
  endsequence

  AST_LOCK_READ: assert property (s_lock_req |-> s_lock_answer)
    else $error("Lock read did not return the lock byte.");
  // Stall first, then the erase level one cycle later.
  sequence s_erase_begin;
    stall_q && !flash_wr_q.erase ##1 flash_wr_q.erase;
  endsequence
  // Store window opened with no read command and no store in its first cycle.
  sequence s_store_armed;
    $rose(ctl_q[BIT_ARM]) && !read_cmd && !cpu_req.spm;
  endsequence
  sequence s_store_quiet;
    !cpu_req.spm [*3];
  endsequence
  // Signature read armed and no instruction in its first cycle.
  sequence s_sig_armed;
    $rose(ctl_q[BIT_SIG]) && !cpu_req.lpm && !cpu_req.spm;
  endsequence
  sequence s_sig_quiet;
    (!cpu_req.lpm && !cpu_req.spm) [*2];
  endsequence

  AST_ERASE_STALL: assert property (start_erase && !op_done |=> s_erase_begin)
    else $error("Erase did not start with a stall.");
  AST_STALL_HOLD: assert property ($rose(stall_q) |-> stall_q [*8])
    else $error("Stall dropped early.");
  AST_PROG_TIME: assert property ($fell(stall_q) |-> $past(stall_len_q) == PROG_W'(PROG_CYCLES - 1))
    else $error("Programming time wrong.");
  AST_ARM_HELD: assert property (stall_q |-> ctl_q[BIT_ARM])
    else $error("Arm bit cleared during an operation.");
  AST_END_CLEAR: assert property ($fell(stall_q) |-> ctl_q == 6'h00)
    else $error("Command bits not cleared at end of operation.");
  AST_SPM_EXPIRE: assert property (s_store_armed ##1 s_store_quiet |=> !ctl_q[BIT_ARM])
    else $error("Store window did not close after four cycles.");
  AST_LPM_EXPIRE: assert property (s_sig_armed ##1 s_sig_quiet |=> ctl_q == 6'h00)
    else $error("Signature read did not clear after three cycles.");
  AST_BAD_PATTERN: assert property (commit && wr_ctrl && !pat_ok && !ctl_q[BIT_ARM] |=> ctl_q == 6'h00)
    else $error("Illegal pattern took effect.");
  AST_EE_BLOCK: assert property (eeprom_write_busy && !stall_q |=> !stall_q)
    else $error("Flash operation started during EEPROM write.");

endmodule : spfc_ctrl
`default_nettype wire

/* File: tb/spfc_cpu_model.sv */
// Behavioural CPU core that issues store and load program instructions.
`timescale 1ns/1ps
`default_nettype none
module spfc_cpu_model
  import spfc_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Requests to the controller
  output var spfc_cpu_req_t cpu_req,
  // Answers from the controller
  input wire logic cpu_stall,
  input wire logic lpm_valid,
  input wire logic [7:0] lpm_data
);
  // ****************************************************************
  // Instruction tasks
  // ****************************************************************
  // The core starts with no instruction under way.
  initial cpu_req = '0;

  // One store pulse, then the stall cycles are counted.
  task automatic store(input logic [15:0] z, input logic [15:0] d, output int stall_n);
    cpu_req <= '{spm: 1'b1, lpm: 1'b0, z_ptr: z, data_pair: d};
    @(posedge aclk);
    cpu_req <= '{spm: 1'b0, lpm: 1'b0, z_ptr: ~z, data_pair: ~d}; // Stale operands are inverted.
    stall_n = 0;
    @(posedge aclk);
    // The core issues nothing more until it is released.
    while (cpu_stall === 1'b1)
    begin
      stall_n++;
      @(posedge aclk);
    end
  endtask : store

  // One load pulse, issued at once so it lands inside the read window.
  task automatic load(input logic [15:0] z, output logic [7:0] q);
    cpu_req <= '{spm: 1'b0, lpm: 1'b1, z_ptr: z, data_pair: 16'h0000};
    @(posedge aclk);
    cpu_req <= '{spm: 1'b0, lpm: 1'b0, z_ptr: ~z, data_pair: 16'hffff};
    q = 'x;
    repeat (4)
    begin
      @(posedge aclk);
      if (lpm_valid === 1'b1)
        q = lpm_data;
    end
  endtask : load
endmodule : spfc_cpu_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the self-program flash controller.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import spfc_pkg::*;
;
  // ****************************************************************
  // Signals and expectations
  // ****************************************************************
  localparam int PROG_N = 100;
  localparam logic [7:0] SIG0 = 8'h3c; // Arbitrary identity value.
  localparam logic [7:0] SIG1 = 8'h4d; // Arbitrary identity value.
  localparam logic [7:0] SIG2 = 8'h5e; // Arbitrary identity value.
  localparam logic [7:0] CAL = 8'h71;
  localparam logic [7:0] TOFF = 8'h08;
  localparam logic [7:0] TGAIN = 8'h95;
  localparam logic [7:0] F_LO = 8'h62;
  localparam logic [7:0] F_HI = 8'hd9;
  localparam logic [7:0] F_EXT = 8'h01;
  localparam logic [7:0] LOCKB = 8'h03;
  logic [7:0] fuse_exp [0:3] = '{~F_LO, ~LOCKB, ~F_EXT, ~F_HI};
  logic [7:0] sig_exp [0:6] = '{SIG0, CAL, SIG1, TOFF, SIG2, TGAIN, RESERVED_BYTE};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic cpu_stall, lpm_valid, ee_busy;
  logic [7:0] awaddr, araddr, lpm_data, flash_rd_byte, q8;
  logic [31:0] wdata, rdata, q32;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] flash_rd_addr;
  logic [15:0] wr_word [0:PAGE_WORDS-1];
  logic [PAGE_W-1:0] wr_page, erase_page;
  spfc_cpu_req_t cpu_req;
  spfc_flash_wr_t flash_wr;
  int n_fail, samples_checked, cycles, wr_count, n, n0;

  // Clock of 5 ns period.
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Flash array: a byte pattern that depends on the whole pointer.
  function automatic logic [7:0] flash_byte(input logic [15:0] z);
    return z[7:0] ^ z[15:8] ^ 8'h5a;
  endfunction : flash_byte
  assign flash_rd_byte = flash_byte(flash_rd_addr);

  spfc_ctrl #(.PROG_CYCLES(PROG_N), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
    .OSC_CAL_BYTE(CAL), .TS_OFFSET_BYTE(TOFF), .TS_GAIN_BYTE(TGAIN)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .cpu_req(cpu_req), .cpu_stall(cpu_stall),
    .lpm_valid(lpm_valid), .lpm_data(lpm_data), .eeprom_write_busy(ee_busy), .fuse_prog_low(F_LO),
    .fuse_prog_high(F_HI), .fuse_prog_ext(F_EXT), .lock_prog(LOCKB), .flash_rd_addr(flash_rd_addr),
    .flash_rd_byte(flash_rd_byte), .flash_wr(flash_wr));

  spfc_cpu_model cpu_u (.aclk(aclk), .cpu_req(cpu_req), .cpu_stall(cpu_stall), .lpm_valid(lpm_valid),
    .lpm_data(lpm_data));

  // Records flash programming and cuts a hang short.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (flash_wr.wr_en === 1'b1)
    begin
      wr_word[flash_wr.word] <= flash_wr.data;
      wr_page <= flash_wr.page;
      wr_count <= wr_count + 1;
    end
    if (flash_wr.erase === 1'b1)
      erase_page <= flash_wr.page;
    if (cycles == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk_val

  task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk_resp

  // Write and read rely on bready and rready being held high throughout.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hf, 2'b11};
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    {araddr, arvalid} <= {a, 1'b1};
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    q = rdata;
    r = rresp;
  endtask : axi_read

  task automatic ctl(input logic [7:0] v);
    axi_write(CTRL_ADDR, {24'h0, v}, resp);
    chk_resp("control write response", RESP_OKAY, resp);
  endtask : ctl

  task automatic rd_ctl(input logic [7:0] exp);
    axi_read(CTRL_ADDR, q32, resp);
    chk_val("control register", {24'h0, exp}, q32);
  endtask : rd_ctl

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid, ee_busy, aresetn} = '0;
    {bready, rready} = 2'b11;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_ctl(CTRL_RESET);
    axi_read(8'h08, q32, resp);
    chk_resp("unmapped read response", RESP_SLVERR, resp);
    chk_val("unmapped read data", 32'h0, q32);
    axi_write(8'h08, 32'h1, resp);
    chk_resp("unmapped write response", RESP_SLVERR, resp);
    ctl(8'h07);
    rd_ctl(8'h00);
    ctl(PAT_FUSE);
    rd_ctl({2'b00, PAT_FUSE});
    repeat (6) @(posedge aclk);
    rd_ctl(8'h00);
    // Fuse, lock and signature bytes, each after its own arming.
    for (int i = 0; i < 4; i++)
    begin
      ctl(PAT_FUSE);
      cpu_u.load(16'(i), q8);
      chk_val("fuse or lock byte", {24'h0, fuse_exp[i]}, {24'h0, q8});
    end
    rd_ctl(8'h00);
    for (int i = 0; i < 7; i++)
    begin
      ctl(PAT_SIG);
      cpu_u.load(16'(i), q8);
      chk_val("signature byte", {24'h0, sig_exp[i]}, {24'h0, q8});
    end
    rd_ctl(8'h00);
    ctl(PAT_SIG);
    repeat (5) @(posedge aclk);
    cpu_u.load(16'h0000, q8);
    chk_val("late load byte", {24'h0, flash_byte(16'h0000)}, {24'h0, q8});
    cpu_u.load(16'h1234, q8);
    chk_val("flash byte", {24'h0, flash_byte(16'h1234)}, {24'h0, q8});
    ctl(PAT_LOAD);
    repeat (6) @(posedge aclk);
    rd_ctl(8'h00);
    // The controller is idle here, so the bench may raise EEPROM busy.
    ee_busy <= 1'b1;
    ctl(PAT_LOAD);
    rd_ctl(8'h00);
    axi_read(STATUS_ADDR, q32, resp);
    chk_val("status while eeprom busy", 32'h2, q32);
    ee_busy <= 1'b0;
    // Software confirms the EEPROM is idle before arming a page write.
    axi_read(STATUS_ADDR, q32, resp);
    chk_val("status before arming", 32'h0, q32);
    n0 = wr_count;
    ctl(PAT_WRITE);
    repeat (6) @(posedge aclk);
    cpu_u.store(16'h0280, 16'h0000, n);
    chk_val("late store stall", 32'h0, 32'(n));
    chk_val("late store words", 32'h0, 32'(wr_count - n0));
    // Load, clear, reload, refused reload, then write the page.
    ctl(PAT_LOAD);
    cpu_u.store(16'h0280, 16'hbeef, n);
    ctl(PAT_CLEAR);
    repeat (6) @(posedge aclk);
    ctl(PAT_LOAD);
    cpu_u.store(16'h0280, 16'hcafe, n);
    ctl(PAT_LOAD);
    cpu_u.store(16'h02ff, 16'h1234, n);
    ctl(PAT_LOAD);
    cpu_u.store(16'h0280, 16'h0000, n);
    n0 = wr_count;
    ctl(PAT_WRITE);
    cpu_u.store(16'h02c3, 16'h5555, n);
    chk_val("write stall", 32'(PROG_N), 32'(n));
    chk_val("words written", 32'(PAGE_WORDS), 32'(wr_count - n0));
    chk_val("write page", 32'h5, 32'(wr_page));
    chk_val("word 0", 32'hcafe, 32'(wr_word[0]));
    chk_val("word 63", 32'h1234, 32'(wr_word[63]));
    chk_val("word 1", 32'(ERASED_WORD), 32'(wr_word[1]));
    rd_ctl(8'h00);
    ctl(PAT_WRITE);
    cpu_u.store(16'h0280, 16'h0000, n);
    chk_val("word 0 after write", 32'(ERASED_WORD), 32'(wr_word[0]));
    ctl(PAT_ERASE);
    cpu_u.store(16'h0391, 16'h0000, n);
    chk_val("erase stall", 32'(PROG_N), 32'(n));
    chk_val("erase page", 32'h7, 32'(erase_page));
    rd_ctl(8'h00);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
